// ===== rtl/evr_top.sv
// Camera event reporter: event capture, record queue, message sending and AXI4-Lite registers
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "evr_map.svh"

module evr_top import evr_pkg::*; #(
  parameter int QUEUE_DEPTH = 8,
  parameter int ADDR_W      = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              acq_begin_trig,
  input  wire logic              waiting_acq_begin,
  input  wire logic              frame_begin_trig,
  input  wire logic              waiting_frame_begin,
  input  wire logic              exposure_done,
  input  wire logic [15:0]       exposure_done_frame_number,
  output logic                   tx_valid,
  output evr_rec_t               tx_rec,
  output logic                   tx_last,
  input  wire logic              tx_ready,
  input  wire logic              host_ack,
  output logic                   irq
);
  localparam int AW       = $clog2(QUEUE_DEPTH);
  localparam int NEV      = `EVR_ENABLE_W;
  localparam int TICK_DIV = `EVR_TICK_NS / `EVR_CLK_NS;

  evr_q_if #(.DEPTH(QUEUE_DEPTH)) q ();

  evr_queue #(.DEPTH(QUEUE_DEPTH)) u_queue (
    .aclk    (aclk),
    .aresetn (aresetn),
    .q       (q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [31:0]          ctrl_q;
  logic [31:0]          mask_q;
  logic [31:0]          timeout_q;
  logic [7:0]           retry_max_q;
  logic [`EVR_STS_W-1:0] sts_q;
  logic [31:0]          tick_hi_snap_q;
  logic [63:0]          tick_q;
  logic [$clog2(TICK_DIV+1)-1:0] div_q;
  logic                 tick_en;
  logic [NEV-1:0]       pend_q;
  logic [63:0]          pend_ts_q [NEV];
  logic [15:0]          expo_frame_q;
  logic [NEV-1:0]       hit;
  logic [NEV-1:0]       new_ok;
  logic [NEV-1:0]       take;
  logic [2:0]           sel;
  logic                 lost;
  evr_tx_state_t        st_q;
  logic [AW:0]          msg_cnt_q;
  logic [AW:0]          idx_q;
  logic [7:0]           retries_q;
  logic [31:0]          timer_q;
  logic                 retire_q;
  logic                 sent_ev_q;
  logic                 ack_ev_q;
  logic                 drop_ev_q;
  logic                 tx_valid_q;
  logic                 tx_last_q;
  evr_rec_t             tx_rec_q;
  logic                 irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp: one tick per TICK_DIV clocks

  assign tick_en = (div_q == ($bits(div_q))'(TICK_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q  <= '0;
      tick_q <= 64'h0;
    end else begin
      div_q <= tick_en ? '0 : div_q + 1'b1;
      if (tick_en) begin
        tick_q <= tick_q + 64'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection, one pending slot per type

  always_comb begin
    hit = {1'b0,
           exposure_done,
           frame_begin_trig & ~waiting_frame_begin,
           frame_begin_trig & waiting_frame_begin,
           acq_begin_trig & ~waiting_acq_begin,
           acq_begin_trig & waiting_acq_begin};
    hit = hit & ctrl_q[NEV-1:0];
    // A record with its slot busy or the queue full is lost
    lost = |(hit[NEV-2:0] & (pend_q[NEV-2:0] | {(NEV-1){q.full}}));
    new_ok = {lost & ctrl_q[`EVR_OVF_BIT] & ~pend_q[NEV-1],
              hit[NEV-2:0] & ~pend_q[NEV-2:0] & ~{(NEV-1){q.full}}};
  end

  // Oldest-type-first is not tracked; lowest type index wins the queue
  always_comb begin
    sel = 3'h0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        sel = 3'(i);
      end
    end
    take = '0;
    if (!q.full && |pend_q) begin
      take[sel] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q       <= '0;
      expo_frame_q <= 16'h0;
      for (int i = 0; i < NEV; i++) begin
        pend_ts_q[i] <= 64'h0;
      end
    end else begin
      for (int i = 0; i < NEV; i++) begin
        if (new_ok[i]) begin
          pend_q[i]    <= 1'b1;
          pend_ts_q[i] <= tick_q;
        end else if (take[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
      if (new_ok[int'(EV_EXPO_DONE)]) begin
        expo_frame_q <= exposure_done_frame_number;
      end
    end
  end

  assign q.push                  = |take;
  assign q.push_rec.kind         = evr_type_t'(sel);
  // Only exposure records carry a frame number; overrun carries nothing extra
  assign q.push_rec.frame_number = (sel == 3'(EV_EXPO_DONE)) ? expo_frame_q : 16'h0;
  assign q.push_rec.channel      = 8'h00;
  assign q.push_rec.stamp        = pend_ts_q[sel];

  ////////////////////////////////////////////////////////////////////////////
  // Message sending with acknowledge, timeout and resend

  assign q.peek_idx   = idx_q[AW-1:0];
  assign q.retire     = retire_q;
  assign q.retire_cnt = msg_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= TX_IDLE;
      msg_cnt_q  <= '0;
      idx_q      <= '0;
      retries_q  <= 8'h00;
      timer_q    <= 32'h0;
      retire_q   <= 1'b0;
      sent_ev_q  <= 1'b0;
      ack_ev_q   <= 1'b0;
      drop_ev_q  <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_last_q  <= 1'b0;
      tx_rec_q   <= '0;
    end else begin
      retire_q  <= 1'b0;
      sent_ev_q <= 1'b0;
      ack_ev_q  <= 1'b0;
      drop_ev_q <= 1'b0;
      case (st_q)
        TX_IDLE: begin
          // Level lags a retire by one cycle, so wait it out
          if (q.level != '0 && !retire_q) begin
            msg_cnt_q <= q.level;
            idx_q     <= '0;
            retries_q <= 8'h00;
            st_q      <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (!tx_valid_q) begin
            tx_rec_q   <= q.peek_rec;
            tx_last_q  <= (idx_q == msg_cnt_q - 1'b1);
            tx_valid_q <= 1'b1;
          end else if (tx_ready) begin
            tx_valid_q <= 1'b0;
            idx_q      <= idx_q + 1'b1;
            if (tx_last_q) begin
              timer_q   <= 32'h0;
              sent_ev_q <= 1'b1;
              st_q      <= TX_WAIT;
            end
          end
        end
        TX_WAIT: begin
          if (host_ack) begin
            retire_q <= 1'b1;
            ack_ev_q <= 1'b1;
            st_q     <= TX_IDLE;
          end else if (timer_q >= timeout_q) begin
            if (retries_q >= retry_max_q) begin
              retire_q  <= 1'b1;
              drop_ev_q <= 1'b1;
              st_q      <= TX_IDLE;
            end else begin
              retries_q <= retries_q + 8'h01;
              idx_q     <= '0;
              st_q      <= TX_SEND;
            end
          end else begin
            timer_q <= timer_q + 32'h1;
          end
        end
        default: begin
          st_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_last  = tx_last_q;
  assign tx_rec   = tx_rec_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_ok;
  logic              rd_ok;
  logic [31:0]       rd_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nv[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_fire = s_axi_arvalid & arready_q;

  always_comb begin
    case (8'(awaddr_q))
      `EVR_CTRL_OFS, `EVR_MASK_OFS, `EVR_TIMEOUT_OFS, `EVR_RETRY_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok = 1'b1;
    case (8'(s_axi_araddr))
      `EVR_CTRL_OFS:    rd_data = ctrl_q;
      `EVR_STATUS_OFS:  rd_data = 32'(sts_q);
      `EVR_MASK_OFS:    rd_data = mask_q;
      `EVR_TIMEOUT_OFS: rd_data = timeout_q;
      `EVR_RETRY_OFS:   rd_data = {24'h0, retry_max_q};
      `EVR_TICK_LO_OFS: rd_data = tick_q[31:0];
      `EVR_TICK_HI_OFS: rd_data = tick_hi_snap_q;
      `EVR_LEVEL_OFS:   rd_data = {13'h0, st_q, 8'(retries_q), 8'(q.level)};
      default: begin
        rd_data = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `EVR_RESP_OKAY;
    end else begin
      awready_q <= ~aw_full_q & ~(s_axi_awvalid & awready_q);
      wready_q  <= ~w_full_q & ~(s_axi_wvalid & wready_q);
      if (s_axi_awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `EVR_RESP_OKAY : `EVR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `EVR_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_q & ~rd_fire;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data;
        rresp_q  <= rd_ok ? `EVR_RESP_OKAY : `EVR_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Host settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= `EVR_CTRL_RST;
      mask_q      <= `EVR_MASK_RST;
      timeout_q   <= `EVR_TIMEOUT_RST;
      retry_max_q <= `EVR_RETRY_RST;
    end else if (wr_fire) begin
      case (8'(awaddr_q))
        `EVR_CTRL_OFS:    ctrl_q    <= merge(ctrl_q, wdata_q, wstrb_q) & 32'(6'h3f);
        `EVR_MASK_OFS:    mask_q    <= merge(mask_q, wdata_q, wstrb_q) & 32'(4'hf);
        `EVR_TIMEOUT_OFS: timeout_q <= merge(timeout_q, wdata_q, wstrb_q);
        `EVR_RETRY_OFS: begin
          if (wstrb_q[0]) begin
            retry_max_q <= wdata_q[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Reading the low word freezes the high word so 64-bit reads do not tear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_hi_snap_q <= 32'h0;
    end else if (rd_fire && 8'(s_axi_araddr) == `EVR_TICK_LO_OFS) begin
      tick_hi_snap_q <= tick_q[63:32];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by reading, a new event wins

  logic [`EVR_STS_W-1:0] sts_set;
  assign sts_set = {lost, drop_ev_q, ack_ev_q, sent_ev_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (rd_fire && 8'(s_axi_araddr) == `EVR_STATUS_OFS) begin
        sts_q <= sts_set;
      end else begin
        sts_q <= sts_q | sts_set;
      end
      irq_q <= |(sts_q & mask_q[`EVR_STS_W-1:0]);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;
endmodule

// ===== rtl/evr_map.svh
// Register offsets, field positions, reset values and timing of the event reporter
`ifndef EVR_MAP_SVH
`define EVR_MAP_SVH

// Register byte offsets
`define EVR_CTRL_OFS      8'h00
`define EVR_STATUS_OFS    8'h04
`define EVR_MASK_OFS      8'h08
`define EVR_TIMEOUT_OFS   8'h0c
`define EVR_RETRY_OFS     8'h10
`define EVR_TICK_LO_OFS   8'h14
`define EVR_TICK_HI_OFS   8'h18
`define EVR_LEVEL_OFS     8'h1c

// Field positions
`define EVR_ENABLE_W      6
`define EVR_STS_SENT      0
`define EVR_STS_ACKED     1
`define EVR_STS_DROPPED   2
`define EVR_STS_OVERRUN   3
`define EVR_STS_W         4
`define EVR_OVF_BIT       5

// Reset values
`define EVR_CTRL_RST      32'h00000000
`define EVR_MASK_RST      32'h00000000
`define EVR_TIMEOUT_RST   32'h0003d090
`define EVR_RETRY_RST     8'h03

// Timing: tick period and clock period in ns
`define EVR_TICK_NS       8
`define EVR_CLK_NS        4

// AXI responses
`define EVR_RESP_OKAY     2'h0
`define EVR_RESP_SLVERR   2'h2

`endif

// ===== rtl/evr_pkg.sv
// Types shared by the event reporter modules
package evr_pkg;

  typedef enum logic [2:0] {
    EV_ACQ_BEGIN   = 3'h0,
    EV_ACQ_OVR     = 3'h1,
    EV_FRAME_BEGIN = 3'h2,
    EV_FRAME_OVR   = 3'h3,
    EV_EXPO_DONE   = 3'h4,
    EV_QUEUE_OVF   = 3'h5
  } evr_type_t;

  typedef struct packed {
    evr_type_t   kind;
    logic [15:0] frame_number;
    logic [7:0]  channel;
    logic [63:0] stamp;
  } evr_rec_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_WAIT = 3'b100
  } evr_tx_state_t;

endpackage

// ===== rtl/evr_q_if.sv
// Connection between the reporter core and its record queue
`timescale 1ns/1ps
interface evr_q_if #(parameter int DEPTH = 8);
  import evr_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic             push;
  evr_rec_t         push_rec;
  logic             full;
  logic [AW:0]      level;
  logic [AW-1:0]    peek_idx;
  evr_rec_t         peek_rec;
  logic             retire;
  logic [AW:0]      retire_cnt;

  modport owner (output push, push_rec, peek_idx, retire, retire_cnt,
                 input  full, level, peek_rec);
  modport store (input  push, push_rec, peek_idx, retire, retire_cnt,
                 output full, level, peek_rec);
endinterface

// ===== rtl/evr_queue.sv
// Event record queue held in flip-flops, read by offset from the oldest entry
`timescale 1ns/1ps
module evr_queue import evr_pkg::*; #(
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  evr_q_if.store   q
);
  localparam int AW = $clog2(DEPTH);

  evr_rec_t       mem_q [DEPTH];
  logic [AW-1:0]  wr_q;
  logic [AW-1:0]  rd_q;
  logic [AW:0]    lvl_q;
  logic           accept;
  logic [AW:0]    gone;

  // Pointers wrap naturally, so DEPTH must be a power of two
  assign accept     = q.push && (lvl_q != (AW+1)'(DEPTH));
  assign gone       = q.retire ? q.retire_cnt : '0;
  assign q.full     = (lvl_q == (AW+1)'(DEPTH));
  assign q.level    = lvl_q;
  assign q.peek_rec = mem_q[rd_q + q.peek_idx];

  always_ff @(posedge aclk) begin
    if (accept) begin
      mem_q[wr_q] <= q.push_rec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      lvl_q <= '0;
    end else begin
      if (accept) begin
        wr_q <= wr_q + AW'(1);
      end
      rd_q  <= rd_q + gone[AW-1:0];
      lvl_q <= lvl_q + (AW+1)'(accept) - gone;
    end
  end
endmodule

// ===== dv/evr_host.sv
// Host model for the event link: takes records and acknowledges messages
`timescale 1ns/1ps
module evr_host (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tx_valid,
  input  wire logic tx_last,
  input  wire logic ack_en,
  input  wire logic slow,
  output logic      tx_ready,
  output logic      host_ack
);
  logic [2:0] ack_dly_q;
  logic [1:0] ph_q;

  // Slow mode takes one cycle in four, so offers must wait
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'h0;
      host_ack <= 1'h0;
      ack_dly_q <= 3'h0;
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      tx_ready <= !slow || ph_q == 2'h3;
      ack_dly_q <= {ack_dly_q[1:0], tx_valid && tx_ready && tx_last && ack_en};
      host_ack <= ack_dly_q[2];
    end
  end
endmodule

// ===== dv/evr_top_sva.sv
// Port checks for the event reporter
`timescale 1ns/1ps
module evr_chk import evr_pkg::*; (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tx_valid,
  input wire evr_rec_t    tx_rec,
  input wire logic        tx_last,
  input wire logic        tx_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_chan_zero;
    tx_valid |-> tx_rec.channel == 8'h00;
  endproperty
  a_chan_zero: assert property (p_chan_zero)
    else $error("record channel not zero");
  property p_ovf_plain;
    tx_valid && tx_rec.kind == EV_QUEUE_OVF |-> tx_rec.frame_number == 16'h0;
  endproperty
  a_ovf_plain: assert property (p_ovf_plain)
    else $error("overflow record carries data");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_rec) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("record offer changed before taken");
  // Minimum quiet gap after a message, whatever the timeout
  property p_ack_wait;
    tx_valid && tx_ready && tx_last |=> !tx_valid [*2];
  endproperty
  a_ack_wait: assert property (p_ack_wait)
    else $error("new offer while acknowledge outstanding");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans)
    else $error("write response missing");
  property p_aw_low;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_low: assert property (p_aw_low)
    else $error("second write address accepted");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
endmodule

bind evr_top evr_chk i_evr_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .tx_valid, .tx_rec, .tx_last, .tx_ready);

// ===== dv/camera_event_reporter_tb.sv
// Self-checking bench for the event reporter
`timescale 1ns/1ps
`include "evr_map.svh"
module camera_event_reporter_tb import evr_pkg::*;;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic        aclk = 1'h0, aresetn = 1'h0, ack_en = 1'h1, slow = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        acq_begin_trig = 1'h0, waiting_acq_begin = 1'h0, frame_begin_trig = 1'h0;
  logic        waiting_frame_begin = 1'h0, exposure_done = 1'h0;
  logic [15:0] exposure_done_frame_number = 16'h0;
  logic        tx_valid, tx_last, tx_ready, host_ack, irq;
  evr_rec_t    tx_rec;
  logic [33:0] axq[$], amq[$], m_v;
  logic [35:0] rq[$], n_v;
  logic [63:0] last_stamp = 64'h0;
  int          bad_count = 0, check_count = 0, seed = 23148;

  always #2 aclk = ~aclk;

  evr_top i_evr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .acq_begin_trig, .waiting_acq_begin, .frame_begin_trig,
    .waiting_frame_begin, .exposure_done, .exposure_done_frame_number, .tx_valid, .tx_rec,
    .tx_last, .tx_ready, .host_ack, .irq);
  evr_host i_evr_host (.aclk, .aresetn, .tx_valid, .tx_last, .ack_en, .slow, .tx_ready,
    .host_ack);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [34:0] e, input logic [34:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Answers come back in order since one access runs at a time
  always @(posedge aclk) begin
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      m_v = amq.pop_front();
      chk("bus answer", {1'h0, axq.pop_front()},
          {1'h0, (s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}) & m_v});
    end
    if (tx_valid && tx_ready) begin
      n_v = rq.pop_front();
      chk("record", n_v[34:0], {tx_rec.kind, tx_rec.frame_number, n_v[15:0] == 16'hffff ?
          16'hffff : 16'(tx_rec.stamp - last_stamp)});
      chk("channel", 35'h0, 35'(tx_rec.channel));
      chk("last", 35'(n_v[35]), 35'(tx_last));
      last_stamp <= tx_rec.stamp;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'h0;
    w_d = 1'h0;
    axq.push_back({r, 32'h0});
    amq.push_back({2'h3, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  // Late rready lets the read answer stand a cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    axq.push_back({r, d});
    amq.push_back({2'h3, m});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // Kinds 0-3: trigger while waiting or not; 4: exposure end
  // l marks the expected last record of its message
  task automatic ev(input logic [2:0] k, input logic nt, input logic [15:0] dl, input logic l);
    logic [15:0] fn;
    fn = 16'($random(seed));
    if (nt)
      rq.push_back({l, k, k == 3'h4 ? fn : 16'h0, dl});
    @(posedge aclk);
    acq_begin_trig <= k < 3'h2;
    waiting_acq_begin <= k == 3'h0;
    frame_begin_trig <= k == 3'h2 || k == 3'h3;
    waiting_frame_begin <= k == 3'h2;
    exposure_done <= k == 3'h4;
    exposure_done_frame_number <= fn;
    @(posedge aclk);
    acq_begin_trig <= 1'h0;
    frame_begin_trig <= 1'h0;
    exposure_done <= 1'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`EVR_CTRL_OFS, `EVR_CTRL_RST, ALL, `EVR_RESP_OKAY);
    rd(`EVR_TIMEOUT_OFS, `EVR_TIMEOUT_RST, ALL, `EVR_RESP_OKAY);
    rd(`EVR_RETRY_OFS, 32'(`EVR_RETRY_RST), ALL, `EVR_RESP_OKAY);
    rd(`EVR_LEVEL_OFS, 32'h10000, 32'h700ff, `EVR_RESP_OKAY);
    rd(8'h20, 32'h0, ALL, `EVR_RESP_SLVERR);
    wr(`EVR_STATUS_OFS, 32'hf, `EVR_RESP_SLVERR);
    v = $random(seed);
    wr(`EVR_TIMEOUT_OFS, v, `EVR_RESP_OKAY);
    rd(`EVR_TIMEOUT_OFS, v, ALL, `EVR_RESP_OKAY);
    wr(`EVR_TIMEOUT_OFS, 32'h14, `EVR_RESP_OKAY);
    wr(`EVR_RETRY_OFS, 32'h1, `EVR_RESP_OKAY);
    wr(`EVR_MASK_OFS, 32'h4, `EVR_RESP_OKAY);
    wr(`EVR_CTRL_OFS, 32'h3f, `EVR_RESP_OKAY);
    $display("test 1 done");
    // Forty cycles between events is twenty ticks
    for (int k = 0; k < 5; k++) begin
      ev(3'(k), 1'h1, k == 0 ? 16'hffff : 16'h14, 1'h1);
      repeat (38) @(posedge aclk);
    end
    $display("test 2 done");
    wr(`EVR_CTRL_OFS, 32'h3e, `EVR_RESP_OKAY);
    ev(3'h0, 1'h0, 16'hffff, 1'h1);
    repeat (38) @(posedge aclk);
    ev(3'h2, 1'h1, 16'hffff, 1'h1);
    repeat (38) @(posedge aclk);
    $display("test 3 done");
    rd(`EVR_STATUS_OFS, 32'h0, 32'h0, `EVR_RESP_OKAY);
    ack_en <= 1'h0;
    ev(3'h4, 1'h1, 16'hffff, 1'h1);
    rq.push_back(rq[$]);
    repeat (120) @(posedge aclk);
    chk("irq", 35'h1, 35'(irq));
    rd(`EVR_STATUS_OFS, 32'h5, ALL, `EVR_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 35'h0, 35'(irq));
    $display("test 4 done");
    wr(`EVR_TIMEOUT_OFS, 32'h3c, `EVR_RESP_OKAY);
    wr(`EVR_RETRY_OFS, 32'h0, `EVR_RESP_OKAY);
    slow <= 1'h0;
    ev(3'h4, 1'h1, 16'hffff, 1'h1);
    repeat (10) @(posedge aclk);
    // Unacked first record keeps one slot, so only seven more fit
    for (int i = 0; i < 9; i++) begin
      ev(3'h4, i < 7, i == 0 ? 16'hffff : 16'h2, i == 6);
      repeat (2) @(posedge aclk);
    end
    rq.push_back({1'h1, 3'h5, 16'h0, 16'hffff});
    repeat (400) @(posedge aclk);
    rd(`EVR_STATUS_OFS, 32'hd, ALL, `EVR_RESP_OKAY);
    rd(`EVR_LEVEL_OFS, 32'h10000, 32'h700ff, `EVR_RESP_OKAY);
    chk("notes left", 35'h0, 35'(rq.size()));
    $display("test 5 done");
    // Mid-run reset: tick count and settings start over
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`EVR_TICK_LO_OFS, 32'h0, 32'hffffff00, `EVR_RESP_OKAY);
    rd(`EVR_CTRL_OFS, `EVR_CTRL_RST, ALL, `EVR_RESP_OKAY);
    chk("irq", 35'h0, 35'(irq));
    $display("test 6 done");
    complete_run();
  end

  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule
